// File: design/tic_pkg.sv
package tic_pkg;

  // ==========================================================
  // register addresses on the special-function bus
  localparam logic [7:0] ADDR_INTERVAL_CONTROL = 8'ha1;
  localparam logic [7:0] ADDR_HUNDREDTHS_COUNT = 8'ha2;
  localparam logic [7:0] ADDR_CLOCK_S_COUNTER = 8'ha3;
  localparam logic [7:0] ADDR_CLOCK_M_COUNTER = 8'ha4;
  localparam logic [7:0] ADDR_HOUR_COUNTER = 8'ha5;
  localparam logic [7:0] ADDR_INTERVAL_VALUE = 8'ha6;

  // ==========================================================
  // interval_control field positions
  localparam int unsigned BIT_TIME_CLOCK_ENABLE = 0;
  localparam int unsigned BIT_INTERVAL_ENABLE = 1;
  localparam int unsigned BIT_INTERVAL_FLAG = 2;
  localparam int unsigned BIT_SINGLE_SHOT_MODE = 3;
  localparam int unsigned BIT_TIMEBASE_SELECT_LO = 4;
  localparam int unsigned BIT_TIMEBASE_SELECT_HI = 5;

  // ==========================================================
  // timebase select codes
  localparam logic [1:0] TB_TICK = 2'h0;
  localparam logic [1:0] TB_SECONDS = 2'h1;
  localparam logic [1:0] TB_MINUTES = 2'h2;
  localparam logic [1:0] TB_HOURS = 2'h3;

  // ==========================================================
  // reset values
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_TIME = 8'h00;
  localparam logic [7:0] RESET_INTERVAL_VALUE = 8'h00;

  // ==========================================================
  // counter limits
  localparam logic [7:0] HUNDREDTHS_MAX = 8'h7f;
  localparam logic [7:0] SECONDS_MAX = 8'h3b;
  localparam logic [7:0] MINUTES_MAX = 8'h3b;
  localparam logic [7:0] HOURS_MAX = 8'h17;

  // ==========================================================
  // timing: one tick is 1/128 s
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_PERIOD_NS = 7812500;
  localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

endpackage

// File: design/wrap_counter.sv
`timescale 1ns/1ps
module wrap_counter #(
  parameter logic [7:0] MAX = 8'h3b
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic load,
  input wire logic [7:0] load_value,
  input wire logic step,
  output logic [7:0] count,
  output logic wrap
);

  // ==========================================================
  // elaboration check
  if (MAX == 8'h00) begin : g_bad_max
    $error("wrap_counter: MAX must be above zero");
  end

  // carry out is combinational so the next stage steps in the same edge
  assign wrap = step && (count == MAX);

  always_ff @(posedge core_clk) begin
    if (rst || clear) begin
      count <= tic_pkg::RESET_TIME;
    end else if (load) begin
      count <= load_value;
    end else if (step) begin
      count <= (count == MAX) ? 8'h00 : count + 8'h01;
    end
  end

endmodule // wrap_counter

// File: design/time_interval_counter.sv
`timescale 1ns/1ps
module time_interval_counter #(
  parameter int unsigned TICK_CYCLES = tic_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic irq_enable,
  output logic [7:0] sfr_rdata,
  output logic irq_req
);

  // ==========================================================
  // elaboration check
  // two edges apart would break the tick spacing check below
  if (TICK_CYCLES < 3) begin : g_bad_tick
    $error("time_interval_counter: TICK_CYCLES must be at least 3");
  end

  localparam int unsigned TW = $clog2(TICK_CYCLES);

  // ==========================================================
  // control state
  logic [1:0] timebase_select;
  logic single_shot_mode;
  logic interval_flag;
  logic interval_enable;
  logic time_clock_enable;
  logic [7:0] interval_value;
  logic [7:0] interval_count;
  logic matched;

  logic wr_ctl;
  logic time_load;
  logic time_clear;
  logic [TW-1:0] tick_cnt;
  logic tick;
  logic [7:0] hundredths_count;
  logic [7:0] clock_s_counter;
  logic [7:0] clock_m_counter;
  logic [7:0] hour_counter;
  logic hund_wrap;
  logic sec_wrap;
  logic min_wrap;
  logic tb_pulse;
  logic ic_step;
  logic [7:0] next_interval_count;
  logic timeout;

  assign wr_ctl = sfr_wr && (sfr_addr == tic_pkg::ADDR_INTERVAL_CONTROL);
  // loads while running would race the carry chain, so they are dropped
  assign time_load = sfr_wr && !time_clock_enable;
  // time registers are cleared on the enable's falling edge only, so values
  // loaded while stopped survive until the clock is started
  assign time_clear = wr_ctl && time_clock_enable
                      && !sfr_wdata[tic_pkg::BIT_TIME_CLOCK_ENABLE];

  // ==========================================================
  // 1/128 s tick from the always-on core clock
  // this domain is meant to stay alive in power-down
  assign tick = time_clock_enable && (tick_cnt == TW'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (rst || !time_clock_enable) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TW'(1);
    end
  end

  // ==========================================================
  // calendar chain
  wrap_counter #(.MAX(tic_pkg::HUNDREDTHS_MAX)) u_hundredths (
    .core_clk(core_clk),
    .rst(rst),
    .clear(time_clear),
    .load(time_load && (sfr_addr == tic_pkg::ADDR_HUNDREDTHS_COUNT)),
    .load_value(sfr_wdata),
    .step(tick),
    .count(hundredths_count),
    .wrap(hund_wrap)
  );

  wrap_counter #(.MAX(tic_pkg::SECONDS_MAX)) u_seconds (
    .core_clk(core_clk),
    .rst(rst),
    .clear(time_clear),
    .load(time_load && (sfr_addr == tic_pkg::ADDR_CLOCK_S_COUNTER)),
    .load_value(sfr_wdata),
    .step(hund_wrap),
    .count(clock_s_counter),
    .wrap(sec_wrap)
  );

  wrap_counter #(.MAX(tic_pkg::MINUTES_MAX)) u_minutes (
    .core_clk(core_clk),
    .rst(rst),
    .clear(time_clear),
    .load(time_load && (sfr_addr == tic_pkg::ADDR_CLOCK_M_COUNTER)),
    .load_value(sfr_wdata),
    .step(sec_wrap),
    .count(clock_m_counter),
    .wrap(min_wrap)
  );

  // hour carry goes nowhere
  wrap_counter #(.MAX(tic_pkg::HOURS_MAX)) u_hours (
    .core_clk(core_clk),
    .rst(rst),
    .clear(time_clear),
    .load(time_load && (sfr_addr == tic_pkg::ADDR_HOUR_COUNTER)),
    .load_value(sfr_wdata),
    .step(min_wrap),
    .count(hour_counter),
    .wrap()
  );

  // ==========================================================
  // timebase selection
  always_comb begin
    unique case (timebase_select)
      tic_pkg::TB_TICK: tb_pulse = tick;
      tic_pkg::TB_SECONDS: tb_pulse = hund_wrap;
      tic_pkg::TB_MINUTES: tb_pulse = sec_wrap;
      tic_pkg::TB_HOURS: tb_pulse = min_wrap;
    endcase
  end

  // ==========================================================
  // interval counter
  assign ic_step = interval_enable && tb_pulse;
  assign next_interval_count = matched ? 8'h00 : interval_count + 8'h01;
  // a value of zero first matches after the counter wraps through 255, then on every further step
  assign timeout = ic_step && (next_interval_count == interval_value);

  always_ff @(posedge core_clk) begin
    if (rst || !interval_enable) begin
      interval_count <= 8'h00;
      matched <= 1'b0;
    end else if (ic_step) begin
      interval_count <= next_interval_count;
      matched <= (next_interval_count == interval_value);
    end
  end

  // ==========================================================
  // control register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timebase_select <= tic_pkg::RESET_CONTROL[tic_pkg::BIT_TIMEBASE_SELECT_HI:tic_pkg::BIT_TIMEBASE_SELECT_LO];
      single_shot_mode <= tic_pkg::RESET_CONTROL[tic_pkg::BIT_SINGLE_SHOT_MODE];
      interval_enable <= tic_pkg::RESET_CONTROL[tic_pkg::BIT_INTERVAL_ENABLE];
      time_clock_enable <= tic_pkg::RESET_CONTROL[tic_pkg::BIT_TIME_CLOCK_ENABLE];
    end else begin
      if (wr_ctl) begin
        timebase_select <= sfr_wdata[tic_pkg::BIT_TIMEBASE_SELECT_HI:tic_pkg::BIT_TIMEBASE_SELECT_LO];
        single_shot_mode <= sfr_wdata[tic_pkg::BIT_SINGLE_SHOT_MODE];
        interval_enable <= sfr_wdata[tic_pkg::BIT_INTERVAL_ENABLE];
        time_clock_enable <= sfr_wdata[tic_pkg::BIT_TIME_CLOCK_ENABLE];
      end
      // the timeout outranks a same-cycle software write
      if (timeout && single_shot_mode) begin
        interval_enable <= 1'b0;
      end
    end
  end

  // set wins over a same-cycle clear so no event is lost
  always_ff @(posedge core_clk) begin
    if (rst) begin
      interval_flag <= tic_pkg::RESET_CONTROL[tic_pkg::BIT_INTERVAL_FLAG];
    end else if (timeout) begin
      interval_flag <= 1'b1;
    end else if (wr_ctl) begin
      interval_flag <= sfr_wdata[tic_pkg::BIT_INTERVAL_FLAG];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      interval_value <= tic_pkg::RESET_INTERVAL_VALUE;
    end else if (sfr_wr && (sfr_addr == tic_pkg::ADDR_INTERVAL_VALUE)) begin
      interval_value <= sfr_wdata;
    end
  end

  // request doubles as the power-down wake line
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= interval_flag && irq_enable;
    end
  end

  // ==========================================================
  // read port, one cycle latency; reserved bits read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else begin
      unique case (sfr_addr)
        tic_pkg::ADDR_INTERVAL_CONTROL: sfr_rdata <= {2'b00, timebase_select, single_shot_mode,
                                                      interval_flag, interval_enable, time_clock_enable};
        tic_pkg::ADDR_HUNDREDTHS_COUNT: sfr_rdata <= hundredths_count;
        tic_pkg::ADDR_CLOCK_S_COUNTER: sfr_rdata <= clock_s_counter;
        tic_pkg::ADDR_CLOCK_M_COUNTER: sfr_rdata <= clock_m_counter;
        tic_pkg::ADDR_HOUR_COUNTER: sfr_rdata <= hour_counter;
        tic_pkg::ADDR_INTERVAL_VALUE: sfr_rdata <= interval_value;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_SEL_HOLD: assert property (
    !wr_ctl |=> timebase_select == $past(timebase_select))
    else $error("timebase select changed without a control write");

  AST_COUNT_HOLD: assert property (
    (interval_enable && !ic_step) |=> interval_count == $past(interval_count))
    else $error("interval count moved without a timebase step");

  AST_TB_SELECT: assert property (
    ic_step |-> ((timebase_select == tic_pkg::TB_TICK && tick)
                 || (timebase_select == tic_pkg::TB_SECONDS && hund_wrap)
                 || (timebase_select == tic_pkg::TB_MINUTES && sec_wrap)
                 || (timebase_select == tic_pkg::TB_HOURS && min_wrap)))
    else $error("interval step without its selected source");

  AST_TB_OVERFLOW: assert property (
    (interval_enable && timebase_select == tic_pkg::TB_MINUTES && sec_wrap && !matched
     && !wr_ctl && !(timeout && single_shot_mode))
    |=> interval_count == $past(interval_count) + 8'h01)
    else $error("minutes timebase did not step on seconds overflow");

  AST_SINGLE_STOP: assert property (
    (timeout && single_shot_mode) |=> !interval_enable ##1 (interval_count == 8'h00))
    else $error("single shot did not stop the interval counter");

  AST_RELOAD: assert property (
    (timeout && !single_shot_mode && !wr_ctl) |=> interval_enable && matched)
    else $error("reload mode lost enable after timeout");

  AST_RESTART_ZERO: assert property (
    (matched && ic_step) |=> interval_count == 8'h00)
    else $error("interval count did not restart at zero");

  AST_FLAG_SET: assert property (
    (ic_step && next_interval_count == interval_value) |=> interval_flag)
    else $error("match did not set interval flag");

  AST_FLAG_HOLD: assert property (
    (interval_flag && !wr_ctl) |=> interval_flag)
    else $error("interval flag cleared without software");

  AST_FLAG_CLEAR: assert property (
    (wr_ctl && !sfr_wdata[tic_pkg::BIT_INTERVAL_FLAG] && !timeout) |=> !interval_flag)
    else $error("software clear of interval flag ignored");

  AST_IRQ: assert property (
    (interval_flag && irq_enable) |=> irq_req)
    else $error("interrupt not raised for set flag");

  AST_IRQ_CAUSE: assert property (
    irq_req |-> $past(interval_flag) && $past(irq_enable))
    else $error("interrupt raised without cause");

  AST_IEN_CLEAR: assert property (
    !interval_enable |=> interval_count == 8'h00)
    else $error("interval counter not zero while disabled");

  AST_TIME_CLOCK_ENABLE_CLEAR: assert property (
    $fell(time_clock_enable) |-> (hundredths_count == 8'h00) && (clock_s_counter == 8'h00)
                                 && (clock_m_counter == 8'h00) && (hour_counter == 8'h00))
    else $error("time registers not cleared when clock stopped");

  AST_TIME_CLOCK_ENABLE_GATE: assert property (
    !time_clock_enable |-> !tick)
    else $error("tick while time clock disabled");

  AST_LOAD: assert property (
    (sfr_wr && !time_clock_enable && sfr_addr == tic_pkg::ADDR_CLOCK_M_COUNTER)
    |=> clock_m_counter == $past(sfr_wdata))
    else $error("minutes load while stopped was lost");

  AST_TICK_SPACING: assert property (
    tick |=> !tick [*2])
    else $error("ticks closer than expected");

  AST_HUND_WRAP: assert property (
    (tick && hundredths_count == tic_pkg::HUNDREDTHS_MAX)
    |=> hundredths_count == 8'h00 && clock_s_counter != $past(clock_s_counter))
    else $error("hundredths did not wrap into seconds");

  AST_SEC_WRAP: assert property (
    (hund_wrap && clock_s_counter == tic_pkg::SECONDS_MAX)
    |=> clock_s_counter == 8'h00 && clock_m_counter != $past(clock_m_counter))
    else $error("seconds did not wrap into minutes");

  AST_MIN_WRAP: assert property (
    (sec_wrap && clock_m_counter == tic_pkg::MINUTES_MAX)
    |=> clock_m_counter == 8'h00 && hour_counter != $past(hour_counter))
    else $error("minutes did not wrap into hours");

  AST_HOUR_WRAP: assert property (
    (min_wrap && hour_counter == tic_pkg::HOURS_MAX) |=> hour_counter == 8'h00)
    else $error("hours did not wrap to zero");

  AST_RESET_ZERO: assert property (
    $past(rst) |-> (hundredths_count == 8'h00) && (hour_counter == 8'h00)
                   && (interval_value == 8'h00) && !irq_req)
    else $error("registers not zero after reset");

  COV_SINGLE: cover property (timeout && single_shot_mode);
  COV_RELOAD: cover property (timeout && !single_shot_mode ##[1:1000] timeout);
  COV_SET_CLEAR: cover property (timeout && wr_ctl && !sfr_wdata[tic_pkg::BIT_INTERVAL_FLAG]);
  COV_SEC_WRAP: cover property (sec_wrap);

endmodule // time_interval_counter

// File: verification/test_time_interval_counter.sv
`timescale 1ns/1ps
module test_time_interval_counter;
  // ==========================================================
  // short tick keeps the carry and interval runs brief
  localparam int unsigned TICK = 16;
  localparam logic [7:0] CTRL = tic_pkg::ADDR_INTERVAL_CONTROL;
  localparam logic [7:0] IVAL = tic_pkg::ADDR_INTERVAL_VALUE;
  localparam logic [7:0] HTH = tic_pkg::ADDR_HUNDREDTHS_COUNT;

  logic core_clk;
  logic rst;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic [7:0] sfr_wdata;
  logic irq_enable;
  logic [7:0] sfr_rdata;
  logic irq_req;
  int fails;
  int cmp_count;
  int cyc = 0;
  int w;
  // time registers before and one tick after enable, per timebase code
  logic [7:0] pre_t [4][4] = '{'{8'h00, 8'h00, 8'h00, 8'h00}, '{8'h7f, 8'h00, 8'h00, 8'h00},
    '{8'h7f, 8'h3b, 8'h00, 8'h00}, '{8'h7f, 8'h3b, 8'h3b, 8'h17}};
  logic [7:0] post_t [4][4] = '{'{8'h01, 8'h00, 8'h00, 8'h00}, '{8'h00, 8'h01, 8'h00, 8'h00},
    '{8'h00, 8'h00, 8'h01, 8'h00}, '{8'h00, 8'h00, 8'h00, 8'h00}};

  time_interval_counter #(.TICK_CYCLES(TICK)) uut (
    .core_clk(core_clk),
    .rst(rst),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .irq_enable(irq_enable),
    .sfr_rdata(sfr_rdata),
    .irq_req(irq_req)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) cyc <= cyc + 1;

  // ==========================================================
  // access tasks: every task is entered and left at a falling edge
  task automatic end_of_test();
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
    w = cyc;
    @(negedge core_clk);
  endtask

  // read data appears one edge after the address is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    @(negedge core_clk);
    chk($sformatf("reg_%h", a), e, sfr_rdata);
  endtask

  task automatic wait_edge(input int n);
    for (int g = 0; g < 200000 && cyc < n; g++) @(negedge core_clk);
    if (cyc != n) begin
      $display("mismatch edge_count expected %0d seen %0d", n, cyc);
      fails++;
      end_of_test();
    end
  endtask

  // control register just before and just after edge n
  task automatic around(input int n, input logic [7:0] before_v, input logic [7:0] after_v);
    wait_edge(n - 1);
    rd(CTRL, before_v);
    rd(CTRL, after_v);
  endtask

  initial begin
    #5000000;
    fails++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    int s;
    rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    irq_enable = 1'b1;
    fails = 0;
    cmp_count = 0;
    w = 0;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    for (int a = 8'ha0; a <= 8'ha6; a++) rd(8'(a), 8'h00);
    wr(CTRL, 8'hc0);
    rd(CTRL, 8'h00);
    wr(IVAL, 8'hff);
    rd(IVAL, 8'hff);
    wr(8'ha0, 8'hff);
    rd(8'ha0, 8'h00);
    // each timebase code, preloaded so the chosen source pulses on the first tick
    for (int k = 0; k < 4; k++) begin
      wr(CTRL, 8'h00);
      for (int i = 0; i < 4; i++) wr(HTH + 8'(i), pre_t[k][i]);
      for (int i = 0; i < 4; i++) rd(HTH + 8'(i), pre_t[k][i]);
      wr(IVAL, 8'h01);
      wr(CTRL, 8'h43 | 8'(k << 4));
      around(w + TICK, 8'h03 | 8'(k << 4), 8'h07 | 8'(k << 4));
      chk("irq_req", 8'h01, {7'h00, irq_req});
      for (int i = 0; i < 4; i++) rd(HTH + 8'(i), post_t[k][i]);
    end
    // reload mode, interval 3: first flag after 3 ticks, then every 4, interrupt masked first
    irq_enable = 1'b0;
    wr(CTRL, 8'h00);
    wr(IVAL, 8'h03);
    wr(CTRL, 8'h03);
    s = w;
    around(s + 3 * TICK, 8'h03, 8'h07);
    chk("irq_req", 8'h00, {7'h00, irq_req});
    wait_edge(s + 5 * TICK);
    rd(CTRL, 8'h07);
    irq_enable = 1'b1;
    @(negedge core_clk);
    @(negedge core_clk);
    chk("irq_req", 8'h01, {7'h00, irq_req});
    wr(CTRL, 8'h03);
    rd(CTRL, 8'h03);
    around(s + 7 * TICK, 8'h03, 8'h07);
    // stop the interval counter at count 2, restart: three fresh steps needed
    wait_edge(s + 10 * TICK);
    wr(CTRL, 8'h01);
    wr(CTRL, 8'h03);
    around(s + 13 * TICK, 8'h03, 8'h07);
    // single shot, interval 2
    wr(CTRL, 8'h00);
    wr(IVAL, 8'h02);
    wr(CTRL, 8'h0b);
    s = w;
    around(s + 2 * TICK, 8'h0b, 8'h0d);
    wr(CTRL, 8'h09);
    wait_edge(s + 7 * TICK);
    rd(CTRL, 8'h09);
    wr(8'ha3, 8'h22);
    rd(8'ha3, 8'h00);
    rd(HTH, 8'h07);
    wr(CTRL, 8'h00);
    rd(HTH, 8'h00);
    wait_edge(w + 2 * TICK);
    rd(HTH, 8'h00);
    end_of_test();
  end
endmodule // test_time_interval_counter
